// ### psc_map.svh
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PSC_REG_DATA 4'h0
`define PSC_REG_LOC 4'h1
`define PSC_REG_CMD 4'h2
`define PSC_REG_MODE 4'h3
`define PSC_REG_TIMER 4'h4
`define PSC_REG_QUEUE 4'h5
`define PSC_REG_STATUS 4'h6
`define PSC_REG_CTRL 4'h7

// ----------------------------------------
// command and memory codes
// ----------------------------------------
`define PSC_OP_WRITE 4'h7
`define PSC_OP_READ 4'h8
`define PSC_CODE_SIG 4'ha
`define PSC_CODE_ODD 4'hb
`define PSC_CODE_CI 4'h8
`define PSC_SUB_TAG 2'h1
`define PSC_LOC_DN_EVEN 2'h0
`define PSC_LOC_DN_ODD 2'h1
`define PSC_LOC_UP_EVEN 2'h2
`define PSC_LOC_UP_ODD 2'h3

// ----------------------------------------
// field positions and values
// ----------------------------------------
`define PSC_LOC_DIR 7
`define PSC_LOC_PAR 0
`define PSC_MODE_COS 0
`define PSC_MODE_HSK 1
`define PSC_TMR_SSR 7
`define PSC_CTRL_ST 0
`define PSC_CTRL_CFR 1
`define PSC_MASK6 8'hfc
`define PSC_MASK8 8'hff
`define PSC_CI_FILL 2'h3
`define PSC_MRMX_IDLE 2'h3

// ----------------------------------------
// timing and queue depth
// ----------------------------------------
`define PSC_TICK_US 250
`define PSC_CLK_MHZ 125
`define PSC_QDEPTH 9

`endif

// ### psc_pkg.sv
package psc_pkg;

   typedef enum logic [2:0] {PM_IDLE, PM_DECENT, PM_CENTRAL, PM_SIG6, PM_SIG8} psc_mode_e;

   typedef struct packed {
      logic [5:0] slot;
      logic [7:0] mon;
      logic [7:0] pcm;
      logic [7:0] pcm_oe;
   } psc_upf_s;

endpackage

// ### psc_buf2.sv
`timescale 1ns/1ps
`default_nettype none

module psc_buf2
#(
   parameter int W = 8
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] e0_q, e0_d, e1_q, e1_d;
   logic [1:0] cnt_q, cnt_d;
   logic vld_q, vld_d;
   logic push, pop;

   assign in_ready = (cnt_q != 2'd2);
   // valid from its own flop, so the port has no decode behind it
   assign out_valid = vld_q;
   assign out_data = e0_q;

   always_comb
   begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      e0_d = e0_q;
      e1_d = e1_q;
      cnt_d = cnt_q;
      unique case ({push, pop})
         2'b10:
         begin
            if (cnt_q == 2'd0)
               e0_d = in_data;
            else
               e1_d = in_data;
            cnt_d = cnt_q + 2'd1;
         end
         2'b01:
         begin
            e0_d = e1_q;
            cnt_d = cnt_q - 2'd1;
         end
         2'b11:
         begin
            // count 2 never pushes, so only 1 is seen here
            e0_d = in_data;
         end
         2'b00: ;
      endcase
      vld_d = (cnt_d != 2'd0);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         e0_q <= '0;
         e1_q <= '0;
         cnt_q <= 2'd0;
         vld_q <= 1'b0;
      end
      else
      begin
         e0_q <= e0_d;
         e1_q <= e1_d;
         cnt_q <= cnt_d;
         vld_q <= vld_d;
      end
   end
endmodule

`default_nettype wire

// ### psc_cq.sv
`timescale 1ns/1ps
`default_nettype none

module psc_cq
#(
   parameter int DEPTH = 9,
   parameter int W = 8
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic clr,
   input wire logic push,
   input wire logic [W-1:0] din,
   input wire logic pop,
   // state
   output logic [W-1:0] head,
   output logic full,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0] mem_q [DEPTH];
   logic [W-1:0] mem_d [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [CW-1:0] cnt_q, cnt_d;

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   assign full = (cnt_q == CW'(DEPTH));
   assign empty = (cnt_q == '0);
   assign head = mem_q[rp_q];

   always_comb
   begin
      mem_d = mem_q;
      wp_d = wp_q;
      rp_d = rp_q;
      cnt_d = cnt_q;
      if (clr)
      begin
         wp_d = '0;
         rp_d = '0;
         cnt_d = '0;
      end
      else if (pop && !empty)
      begin
         rp_d = nxt(rp_q);
         cnt_d = cnt_q - CW'(1);
      end
      // a push in the clearing cycle survives the clear
      if (push && (clr || !full))
      begin
         mem_d[wp_d] = din;
         wp_d = nxt(wp_d);
         cnt_d = cnt_d + CW'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_q[i] <= '0;
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         mem_q <= mem_d;
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

`default_nettype wire

// ### psc_top.sv
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"

// Function
// (RULE_01) 8-bit mode: even feature, odd signaling byte
// (RULE_02) feature channel follows handshake or non-handshake setting
// (RULE_03) host codes for 8-bit signaling pair
// (RULE_04) host codes for 6-bit signaling pair
// (RULE_05) double last-look filter, programmable period
// (RULE_06) actual value stored every frame
// (RULE_07) stable value updated after confirmed change
// (RULE_08) stable change raises irq, queues address
// (RULE_09) command/indication exchanged; changes queued
// (RULE_10) central mode switches D bits via subslot
// (RULE_11) inactive D bits: high-Z or ones
// (RULE_12) monitor positions belong to monitor handler
// (RULE_13) two-bit direction/parity location code
// (RULE_14) command 0111 writes code and data
// (RULE_15) nine-entry queue; changes pend while full
// (RULE_16) period: one frame or timer period
// (RULE_17) host programs all four locations first
module psc_top
   import psc_pkg::*;
#(
   parameter int NPAIR = 16,
   parameter int QDEPTH = `PSC_QDEPTH,
   parameter int TICK_CYC = `PSC_TICK_US * `PSC_CLK_MHZ
)
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // register port
   input wire logic [3:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   // serial interface pins
   input wire logic SER_FSYNC,
   input wire logic SER_STB,
   input wire logic [7:0] SER_DIN,
   output logic [7:0] SER_DOUT,
   output logic [7:0] SER_DOUT_OE,
   // monitor handler and pcm side
   input wire logic [7:0] MON_DOWN,
   input wire logic [1:0] MON_MRMX,
   input wire logic [7:0] PCM_DOWN,
   output psc_upf_s UPF_DATA,
   output logic UPF_VALID,
   input wire logic UPF_READY,
   // status
   output logic SIG_CHANGE_IRQ
);
   localparam int PW = $clog2(NPAIR);
   localparam int SW = PW + 1;
   localparam int LW = PW + 2;
   localparam int NLOC = 4 * NPAIR;
   localparam int TW = $clog2(TICK_CYC);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [LW-1:0] cm_idx(input logic [PW-1:0] pr, input logic [1:0] loc);
      return {pr, loc};
   endfunction

   function automatic logic [7:0] sub_place(input logic [1:0] d, input logic [3:0] code);
      return {6'h00, d} << {code[1:0], 1'b0};
   endfunction

   function automatic psc_mode_e pm_dec(input logic [3:0] de, input logic [3:0] dodd,
                                        input logic [3:0] ue);
      if (de == `PSC_CODE_SIG && dodd == `PSC_CODE_ODD && ue == `PSC_CODE_SIG)
         return PM_SIG6; // RULE_04
      if (de == `PSC_CODE_SIG && dodd == `PSC_CODE_ODD && ue == `PSC_CODE_ODD)
         return PM_SIG8; // RULE_03
      if (ue == `PSC_CODE_CI && dodd[3:2] == `PSC_SUB_TAG)
         return PM_CENTRAL;
      if (ue == `PSC_CODE_CI)
         return PM_DECENT;
      return PM_IDLE;
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [2:0] fs_s_q, stb_s_q;
   logic [7:0] din1_q, din2_q;
   logic [3:0] code_q [NLOC];
   logic [3:0] code_d [NLOC];
   logic [7:0] mem_q [NLOC];
   logic [7:0] mem_d [NLOC];
   logic [7:0] prev_q [NPAIR];
   logic [7:0] prev_d [NPAIR];
   logic [7:0] data_q, data_d, loc_q, loc_d, tmr_q, tmr_d, rdata_q, rdata_d;
   logic [1:0] mode_q, mode_d;
   logic [7:0] dout_q, dout_d, doe_q, doe_d, pend_b_q, pend_b_d;
   logic [SW-1:0] slot_q, slot_d, pend_s_q, pend_s_d;
   logic pend_v_q, pend_v_d, samp_q, samp_d, ovr_q, ovr_d, irq_q;
   logic run_q, run_d, due_q, due_d;
   logic [TW-1:0] sub_q, sub_d;
   logic [6:0] unit_q, unit_d;

   logic fs_edge, stb_edge, eng_go, eng_sig, eng_ci, ci_diff, sig_hit, buf_rdy;
   logic q_push, q_pop, q_clr, q_full, q_empty, upf_v, stab_upd;
   logic [7:0] q_din, q_head, dev, mk, ub;
   logic [1:0] mrmx;
   logic [SW-1:0] cur;
   logic [PW-1:0] dp, up;
   logic [LW-1:0] bi, ia, ib;
   psc_mode_e dn_md, up_md;
   psc_upf_s upf_w;

   // ----------------------------------------
   // decode of the current slot and pending word
   // ----------------------------------------
   always_comb
   begin
      fs_edge = fs_s_q[1] & ~fs_s_q[2];
      stb_edge = stb_s_q[1] & ~stb_s_q[2];
      cur = fs_edge ? '0 : slot_q;
      dp = cur[SW-1:1];
      up = pend_s_q[SW-1:1];
      ub = pend_b_q;
      // bit 7 picks direction, bit 0 parity
      bi = cm_idx(loc_q[PW:1], {loc_q[`PSC_LOC_DIR], loc_q[`PSC_LOC_PAR]}); // RULE_13
      ia = cm_idx(up, `PSC_LOC_UP_EVEN);
      ib = cm_idx(up, `PSC_LOC_UP_ODD);
      dn_md = pm_dec(code_q[cm_idx(dp, `PSC_LOC_DN_EVEN)], code_q[cm_idx(dp, `PSC_LOC_DN_ODD)],
                     code_q[cm_idx(dp, `PSC_LOC_UP_EVEN)]);
      up_md = pm_dec(code_q[cm_idx(up, `PSC_LOC_DN_EVEN)], code_q[cm_idx(up, `PSC_LOC_DN_ODD)],
                     code_q[ia]);
      dev = mem_q[cm_idx(dp, `PSC_LOC_DN_EVEN)];
      mrmx = mode_q[`PSC_MODE_HSK] ? MON_MRMX : `PSC_MRMX_IDLE; // RULE_02
      mk = (up_md == PM_SIG6) ? `PSC_MASK6 : `PSC_MASK8;
      eng_go = pend_v_q && buf_rdy;
      eng_sig = eng_go && pend_s_q[0] && (up_md == PM_SIG6 || up_md == PM_SIG8);
      eng_ci = eng_go && pend_s_q[0] && (up_md == PM_DECENT || up_md == PM_CENTRAL);
      // two equal samples in a row that differ from stable
      sig_hit = ((ub ^ prev_q[up]) & mk) == 8'h00 && ((ub ^ mem_q[ib]) & mk) != 8'h00; // RULE_05
      ci_diff = ub[5:2] != mem_q[ia][5:2];
   end

   // ----------------------------------------
   // registers, memory and channel engine
   // ----------------------------------------
   always_comb
   begin
      code_d = code_q;
      mem_d = mem_q;
      prev_d = prev_q;
      data_d = data_q;
      loc_d = loc_q;
      mode_d = mode_q;
      tmr_d = tmr_q;
      rdata_d = 8'h00;
      dout_d = dout_q;
      doe_d = doe_q;
      slot_d = slot_q;
      samp_d = samp_q;
      pend_v_d = pend_v_q;
      pend_b_d = pend_b_q;
      pend_s_d = pend_s_q;
      ovr_d = ovr_q;
      q_push = 1'b0;
      q_din = 8'h00;
      q_pop = 1'b0;
      q_clr = 1'b0;
      upf_v = 1'b0;
      upf_w = '0;
      stab_upd = 1'b0;
      if (fs_edge)
      begin
         slot_d = '0;
         samp_d = tmr_q[`PSC_TMR_SSR] | due_q; // RULE_16
      end
      if (eng_go)
         pend_v_d = 1'b0;
      if (stb_edge)
      begin
         slot_d = cur + SW'(1);
         // a word still waiting here is overwritten
         if (pend_v_q && !eng_go)
            ovr_d = 1'b1;
         pend_v_d = 1'b1;
         pend_b_d = din2_q;
         pend_s_d = cur;
         dout_d = 8'hff;
         doe_d = 8'h00;
         if (!cur[0] && dn_md != PM_IDLE)
         begin
            dout_d = MON_DOWN; // RULE_12
            doe_d = 8'hff;
         end
         else if (cur[0])
            unique case (dn_md)
               PM_SIG8:
               begin
                  dout_d = dev; // RULE_01
                  doe_d = 8'hff;
               end
               PM_SIG6:
               begin
                  dout_d = {dev[7:2], dev[1:0] & mrmx}; // RULE_02
                  doe_d = 8'hff;
               end
               PM_DECENT:
               begin
                  dout_d = {`PSC_CI_FILL, dev[5:2], mrmx};
                  doe_d = {{2{mode_q[`PSC_MODE_COS]}}, 6'h3f}; // RULE_11
               end
               PM_CENTRAL:
               begin
                  dout_d = {PCM_DOWN >> {code_q[cm_idx(dp, `PSC_LOC_DN_ODD)][1:0], 1'b0}};
                  dout_d = {dout_d[1:0], dev[5:2], mrmx}; // RULE_10
                  doe_d = 8'hff;
               end
               PM_IDLE: ;
            endcase
      end
      if (eng_go && up_md != PM_IDLE)
      begin
         upf_v = 1'b1;
         upf_w.slot = 6'(pend_s_q);
         upf_w.mon = ub; // RULE_12
         if (pend_s_q[0] && up_md == PM_CENTRAL)
         begin
            upf_w.pcm = sub_place(ub[7:6], code_q[ib]); // RULE_10
            upf_w.pcm_oe = sub_place(2'h3, code_q[ib]);
         end
      end
      if (eng_sig)
      begin
         mem_d[ia] = ub; // RULE_06
         if (samp_q)
         begin
            prev_d[up] = ub;
            // a full queue leaves the change to be found again
            if (sig_hit && !q_full) // RULE_15
            begin
               mem_d[ib] = ub; // RULE_07
               stab_upd = 1'b1;
               q_push = 1'b1; // RULE_08
               q_din = {1'b1, 7'({up, 1'b1})};
            end
         end
      end
      if (eng_ci && ci_diff && !q_full) // RULE_15
      begin
         mem_d[ia] = {`PSC_CI_FILL, ub[5:2], `PSC_CI_FILL}; // RULE_09
         q_push = 1'b1;
         q_din = {1'b1, 7'({up, 1'b0})};
      end
      if (REG_WR)
         unique case (REG_ADDR)
            `PSC_REG_DATA: data_d = REG_WDATA;
            `PSC_REG_LOC: loc_d = REG_WDATA;
            `PSC_REG_CMD:
               if (REG_WDATA[7:4] == `PSC_OP_WRITE)
               begin
                  code_d[bi] = REG_WDATA[3:0]; // RULE_14
                  mem_d[bi] = data_q;
               end
               else if (REG_WDATA[7:4] == `PSC_OP_READ)
                  data_d = mem_q[bi];
            `PSC_REG_MODE: mode_d = REG_WDATA[1:0];
            `PSC_REG_TIMER: tmr_d = REG_WDATA;
            `PSC_REG_CTRL: q_clr = REG_WDATA[`PSC_CTRL_CFR];
            default: ;
         endcase
      if (REG_RD)
         unique case (REG_ADDR)
            `PSC_REG_DATA: rdata_d = data_q;
            `PSC_REG_LOC: rdata_d = loc_q;
            `PSC_REG_MODE: rdata_d = {6'h00, mode_q};
            `PSC_REG_TIMER: rdata_d = tmr_q;
            `PSC_REG_QUEUE:
            begin
               rdata_d = q_empty ? 8'h00 : q_head;
               q_pop = 1'b1;
            end
            `PSC_REG_STATUS:
            begin
               rdata_d = {5'h00, ovr_q, run_q, !q_empty};
               ovr_d = stb_edge && pend_v_q && !eng_go;
            end
            default: rdata_d = 8'h00;
         endcase
   end

   // ----------------------------------------
   // last-look period timer
   // ----------------------------------------
   always_comb
   begin
      run_d = run_q;
      sub_d = sub_q;
      unit_d = unit_q;
      due_d = due_q && !fs_edge;
      if (run_q)
      begin
         if (sub_q == TW'(TICK_CYC - 1))
         begin
            sub_d = '0;
            // (1 + value) ticks of the base period
            if (unit_q == tmr_q[6:0]) // RULE_16
            begin
               unit_d = 7'h00;
               due_d = 1'b1;
            end
            else
               unit_d = unit_q + 7'h01;
         end
         else
            sub_d = sub_q + TW'(1);
      end
      if (REG_WR && REG_ADDR == `PSC_REG_TIMER)
         run_d = 1'b0;
      if (REG_WR && REG_ADDR == `PSC_REG_CTRL && REG_WDATA[`PSC_CTRL_ST])
      begin
         run_d = 1'b1;
         sub_d = '0;
         unit_d = 7'h00;
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         fs_s_q <= 3'h0;
         stb_s_q <= 3'h0;
         din1_q <= 8'h00;
         din2_q <= 8'h00;
         for (int i = 0; i < NLOC; i++)
         begin
            code_q[i] <= 4'h0;
            mem_q[i] <= 8'h00;
         end
         for (int i = 0; i < NPAIR; i++)
            prev_q[i] <= 8'h00;
         data_q <= 8'h00;
         loc_q <= 8'h00;
         mode_q <= 2'h0;
         tmr_q <= 8'h00;
         rdata_q <= 8'h00;
         dout_q <= 8'hff;
         doe_q <= 8'h00;
         slot_q <= '0;
         samp_q <= 1'b0;
         pend_v_q <= 1'b0;
         pend_b_q <= 8'h00;
         pend_s_q <= '0;
         ovr_q <= 1'b0;
         irq_q <= 1'b0;
         run_q <= 1'b0;
         due_q <= 1'b0;
         sub_q <= '0;
         unit_q <= 7'h00;
      end
      else
      begin
         fs_s_q <= {fs_s_q[1:0], SER_FSYNC};
         stb_s_q <= {stb_s_q[1:0], SER_STB};
         din1_q <= SER_DIN;
         din2_q <= din1_q;
         code_q <= code_d;
         mem_q <= mem_d;
         prev_q <= prev_d;
         data_q <= data_d;
         loc_q <= loc_d;
         mode_q <= mode_d;
         tmr_q <= tmr_d;
         rdata_q <= rdata_d;
         dout_q <= dout_d;
         doe_q <= doe_d;
         slot_q <= slot_d;
         samp_q <= samp_d;
         pend_v_q <= pend_v_d;
         pend_b_q <= pend_b_d;
         pend_s_q <= pend_s_d;
         ovr_q <= ovr_d;
         irq_q <= !q_empty; // RULE_08
         run_q <= run_d;
         due_q <= due_d;
         sub_q <= sub_d;
         unit_q <= unit_d;
      end
   end

   assign REG_RDATA = rdata_q;
   assign SER_DOUT = dout_q;
   assign SER_DOUT_OE = doe_q;
   assign SIG_CHANGE_IRQ = irq_q;

   // ----------------------------------------
   // change queue and upstream buffer
   // ----------------------------------------
   psc_cq #(.DEPTH(QDEPTH), .W(8)) u_queue (
      .clk(CLK_SYS), .rst(RST), .clr(q_clr), .push(q_push), .din(q_din),
      .pop(q_pop), .head(q_head), .full(q_full), .empty(q_empty));

   // a stall here holds the pending word, so the engine waits
   psc_buf2 #(.W($bits(psc_upf_s))) u_buf (
      .clk(CLK_SYS), .rst(RST), .in_valid(upf_v), .in_ready(buf_rdy), .in_data(upf_w),
      .out_valid(UPF_VALID), .out_ready(UPF_READY), .out_data(UPF_DATA));

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   sequence s_push;
      q_push ##1 !q_clr;
   endsequence
   sequence s_clr;
      q_clr && !q_push;
   endsequence

   AST_CM_WRITE: assert property (REG_WR && REG_ADDR == `PSC_REG_CMD && // RULE_14
      REG_WDATA[7:4] == `PSC_OP_WRITE |=> code_q[$past(bi)] == $past(REG_WDATA[3:0])
      && mem_q[$past(bi)] == $past(data_q)) else $error("memory write lost");
   AST_QFULL: assert property (q_full |-> !q_push) else $error("push into full queue"); // RULE_15
   AST_IRQ: assert property (s_push |=> SIG_CHANGE_IRQ) else $error("irq not raised"); // RULE_08
   AST_CLR: assert property (s_clr |=> q_empty ##1 !SIG_CHANGE_IRQ) else $error("clear failed"); // RULE_09
   AST_STABLE: assert property (stab_upd |-> q_push && samp_q && sig_hit) // RULE_07
      else $error("stable update without confirmed change");
   AST_ACTUAL: assert property (eng_sig && !REG_WR |=> mem_q[$past(ia)] == $past(pend_b_q)) // RULE_06
      else $error("actual value not stored");
   AST_SIG8: assert property (stb_edge && cur[0] && dn_md == PM_SIG8 |=> // RULE_01
      SER_DOUT == $past(dev) && SER_DOUT_OE == 8'hff) else $error("signaling byte wrong");
   AST_INACT: assert property (stb_edge && cur[0] && dn_md == PM_DECENT |=> // RULE_11
      SER_DOUT_OE[7:6] == {2{$past(mode_q[`PSC_MODE_COS])}}) else $error("inactive bits wrong");
   AST_SAMP: assert property (fs_edge && tmr_q[`PSC_TMR_SSR] |=> samp_q) // RULE_16
      else $error("frame sampling not selected");
   AST_CI: assert property (eng_ci && ci_diff && !q_full |-> q_push) // RULE_09
      else $error("indication change not queued");
endmodule

`default_nettype wire

// ### psc_sub_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// subscriber side: NSLOT slots a frame, 8 cycles a slot
// ----------------------------------------
module psc_sub_model
#(
   parameter int NSLOT = 4
)
(
   // clock
   input wire logic clk,
   // upstream bytes, slot 0 lowest
   input wire logic [NSLOT*8-1:0] up,
   // serial pins
   input wire logic [7:0] dout,
   output logic fsync,
   output logic stb,
   output logic [7:0] din,
   // downstream bytes caught per slot
   output logic [NSLOT*8-1:0] seen
);
   logic [2:0] ph = 3'h0;
   int slot = 0;

   initial
   begin
      fsync = 1'b0;
      stb = 1'b0;
      din = 8'h00;
      seen = '0;
   end

   // din moves only at slot end, well clear of the strobe rise
   always @(posedge clk)
   begin
      ph <= ph + 3'h1;
      if (ph == 3'h0)
      begin
         stb <= 1'b1;
         fsync <= (slot == 0);
      end
      if (ph == 3'h4)
      begin
         stb <= 1'b0;
         fsync <= 1'b0;
      end
      if (ph == 3'h7)
      begin
         seen[slot*8 +: 8] <= dout;
         slot <= (slot + 1) % NSLOT;
         din <= up[((slot + 1) % NSLOT)*8 +: 8];
      end
   end
endmodule

`default_nettype wire

// ### psc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"

module psc_top_bench
   import psc_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic fsync;
   logic stb;
   logic [7:0] din;
   logic [7:0] dout;
   logic [7:0] dout_oe;
   logic [7:0] mon_down = 8'h5a;
   logic [1:0] mrmx = 2'h1;
   logic [7:0] pcm_down = 8'hc3;
   psc_upf_s upf;
   logic upf_valid;
   logic upf_ready = 1'b1;
   logic irq;
   logic [31:0] up = 32'hd6_00_df_00;
   logic [31:0] seen;
   int bad_count = 0;
   int comparisons = 0;

   always #4 clk = ~clk;

   // short tick keeps the timer within one frame
   psc_top #(.TICK_CYC(4)) DUT (.CLK_SYS(clk), .RST(rst), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .SER_FSYNC(fsync), .SER_STB(stb), .SER_DIN(din), .SER_DOUT(dout),
      .SER_DOUT_OE(dout_oe), .MON_DOWN(mon_down), .MON_MRMX(mrmx), .PCM_DOWN(pcm_down),
      .UPF_DATA(upf), .UPF_VALID(upf_valid), .UPF_READY(upf_ready),
      .SIG_CHANGE_IRQ(irq));

   // released bits show the inverse, so a missing release is seen
   psc_sub_model #(.NSLOT(4)) sub (.clk(clk), .up(up), .dout(dout ^ ~dout_oe), .fsync(fsync),
      .stb(stb), .din(din), .seen(seen));

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata & m, exp);
   endtask

   task automatic prog(input logic [7:0] loc, input logic [3:0] code, input logic [7:0] d);
      wr(`PSC_REG_DATA, d);
      wr(`PSC_REG_LOC, loc);
      wr(`PSC_REG_CMD, {`PSC_OP_WRITE, code});
   endtask

   task automatic peek(input logic [7:0] loc, input logic [7:0] exp);
      wr(`PSC_REG_LOC, loc);
      wr(`PSC_REG_CMD, {`PSC_OP_READ, 4'h0});
      rd(`PSC_REG_DATA, 8'hfc, exp);
   endtask

   task automatic frames(input int n);
      repeat (n * 32) @(posedge clk);
      #1;
   endtask

   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // pair 0 six-bit, pair 1 eight-bit
      prog(8'h00, `PSC_CODE_SIG, 8'h47);
      prog(8'h01, `PSC_CODE_ODD, 8'h00);
      prog(8'h80, `PSC_CODE_SIG, 8'hdf);
      prog(8'h81, `PSC_CODE_SIG, 8'hdf);
      prog(8'h02, `PSC_CODE_SIG, 8'h45);
      prog(8'h03, `PSC_CODE_ODD, 8'h00);
      prog(8'h82, `PSC_CODE_ODD, 8'hd6);
      prog(8'h83, `PSC_CODE_ODD, 8'hd6);
      wr(`PSC_REG_TIMER, 8'h80);
      wr(`PSC_REG_CTRL, 8'h02);
      frames(4);
      chk(seen[7:0], 8'h5a);
      chk(seen[15:8], 8'h47);
      chk(seen[23:16], 8'h5a);
      chk(seen[31:24], 8'h45);
      chk({7'h0, irq}, 8'h00);
      rd(`PSC_REG_QUEUE, 8'hff, 8'h00);
      wr(`PSC_REG_MODE, 8'h02);
      frames(2);
      chk(seen[15:8], 8'h45);
      wr(`PSC_REG_MODE, 8'h00);
      $display("test downstream done");
      up[15:8] <= 8'hab;
      frames(5);
      chk({7'h0, irq}, 8'h01);
      rd(`PSC_REG_QUEUE, 8'hff, 8'h81);
      rd(`PSC_REG_QUEUE, 8'hff, 8'h00);
      peek(8'h81, 8'ha8);
      peek(8'h80, 8'ha8);
      $display("test six-bit change done");
      // timer stopped: no sampling until it is started
      wr(`PSC_REG_TIMER, 8'h00);
      up[15:8] <= 8'h33;
      frames(4);
      chk({7'h0, irq}, 8'h00);
      wr(`PSC_REG_CTRL, 8'h01);
      frames(4);
      rd(`PSC_REG_STATUS, 8'h03, 8'h03);
      rd(`PSC_REG_QUEUE, 8'hff, 8'h81);
      $display("test timer period done");
      // sink stalls: words held, change still reported after release
      @(posedge clk);
      upf_ready <= 1'b0;
      up[31:24] <= 8'h5c;
      frames(3);
      chk({7'h0, upf_valid}, 8'h01);
      @(posedge clk);
      upf_ready <= 1'b1;
      frames(4);
      rd(`PSC_REG_QUEUE, 8'hff, 8'h83);
      peek(8'h83, 8'h5c);
      up[15:8] <= 8'h77;
      frames(4);
      rd(`PSC_REG_STATUS, 8'h04, 8'h04);
      wr(`PSC_REG_CTRL, 8'h02);
      rd(`PSC_REG_STATUS, 8'h05, 8'h00);
      chk({7'h0, irq}, 8'h00);
      $display("test stall and reset done");
      // pair 0 to decentral, then central with a pcm subslot
      up[15:8] <= 8'hc3;
      prog(8'h80, `PSC_CODE_CI, 8'hff);
      frames(2);
      rd(`PSC_REG_QUEUE, 8'hff, 8'h80);
      peek(8'h80, 8'hc0);
      chk(seen[15:8], 8'h07);
      wr(`PSC_REG_MODE, 8'h01);
      frames(2);
      chk(seen[15:8], 8'hc7);
      prog(8'h81, 4'h5, 8'h00);
      prog(8'h01, 4'h6, 8'h00);
      frames(2);
      chk(seen[15:8], 8'h07);
      do
      begin
         @(posedge clk);
         #1;
      end
      while (!(upf_valid && upf.slot == 6'h01));
      chk(upf.mon, 8'hc3);
      chk(upf.pcm, 8'h0c);
      chk(upf.pcm_oe, 8'h0c);
      $display("test d channel done");
      stop_test();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      stop_test();
   end
endmodule

`default_nettype wire
